//--- hdl/emu_evt_if.sv
// events and state passed between the port decoder and the status flag unit
`timescale 1ns/100ps
interface emu_evt_if;
  logic       port_wr;
  logic       port_cmd;
  logic       port_rd_data;
  logic [7:0] port_data;
  logic       mem_wr_status;
  logic       mem_wr_input;
  logic [7:0] mem_data;
  logic [7:0] status;
  logic [7:0] input_byte;

  modport ctrl  (output port_wr, port_cmd, port_rd_data, port_data,
                 output mem_wr_status, mem_wr_input, mem_data,
                 input  status, input_byte);
  modport flags (input  port_wr, port_cmd, port_rd_data, port_data,
                 input  mem_wr_status, mem_wr_input, mem_data,
                 output status, input_byte);
endinterface // emu_evt_if

//--- hdl/emu_status_flags.sv
// status flags and input buffer of the legacy emulation
`timescale 1ns/100ps
module emu_status_flags (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // events from the decoder
  emu_evt_if.flags evt
);

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] input_byte;
  } flags_state_t;

  flags_state_t state_ff;
  flags_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (evt.port_rd_data) begin
      nxt_state.status[legacy_emu_pkg::STS_OUT_FULL] = 1'b0;
    end
    if (evt.mem_wr_status) begin
      nxt_state.status = evt.mem_data;
    end
    if (evt.mem_wr_input) begin
      nxt_state.input_byte = evt.mem_data;
    end
    // port writes come last so their flag sets win
    if (evt.port_wr) begin
      nxt_state.input_byte = evt.port_data;
      nxt_state.status[legacy_emu_pkg::STS_IN_FULL] = 1'b1;
      nxt_state.status[legacy_emu_pkg::STS_CMD]     = evt.port_cmd;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= '{status: legacy_emu_pkg::STATUS_RESET,
                    input_byte: legacy_emu_pkg::BYTE_RESET};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign evt.status     = state_ff.status;
  assign evt.input_byte = state_ff.input_byte;

endmodule // emu_status_flags

//--- hdl/legacy_emu_pkg.sv
// constants, field positions and decode helper for the legacy keyboard/mouse emulation
package legacy_emu_pkg;

  // memory-space offsets of the emulation registers
  localparam logic [8:0]  OFS_CONTROL    = 9'h100;
  localparam logic [8:0]  OFS_INPUT      = 9'h104;
  localparam logic [8:0]  OFS_OUTPUT     = 9'h108;
  localparam logic [8:0]  OFS_STATUS     = 9'h10C;

  // legacy I/O ports and the base address that qualifies them
  localparam logic [15:0] PORT_DATA      = 16'h0060;
  localparam logic [15:0] PORT_CMD       = 16'h0064;
  localparam logic [15:0] LEGACY_IO_BASE = 16'h0060;

  // emulation_control fields
  localparam int unsigned CTL_EMU_ON     = 0;
  localparam int unsigned CTL_EMU_INT    = 1;
  localparam int unsigned CTL_CHAR_PEND  = 2;
  localparam int unsigned CTL_IRQ_GATE   = 3;
  localparam int unsigned CTL_WIDTH      = 4;

  // emulation_status fields
  localparam int unsigned STS_OUT_FULL   = 0;
  localparam int unsigned STS_IN_FULL    = 1;
  localparam int unsigned STS_CMD        = 3;
  localparam int unsigned STS_AUX        = 5;

  // reset values
  localparam logic [3:0]  CONTROL_RESET  = 4'h0;
  localparam logic [7:0]  STATUS_RESET   = 8'h00;
  localparam logic [7:0]  BYTE_RESET     = 8'h00;
  localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;

  // true when a byte address hits a register word
  function automatic logic reg_hit(input logic [8:0] addr, input logic [8:0] ofs);
    reg_hit = (addr[8:2] == ofs[8:2]);
  endfunction

endpackage

//--- hdl/legacy_kbd_emulation.sv
// legacy keyboard and mouse emulation: memory window, port 60h/64h decode, irq lines
//
// Behaviour
// - emulation works only while the legacy strap pin is high, else nothing is decoded.
// - with decode select low, ports 60h and 64h are captured whatever the I/O base holds.
// - with decode select high, the ports are captured only when the I/O base equals 60h.
// - the four emulation registers sit in memory space at offsets 100h to 10Ch.
// - a read of port 64h returns the status register and changes nothing.
// - a write to port 60h stores the byte, sets input full and clears command flag.
// - a write to port 64h stores the byte and sets input full and command flag.
// - a read of port 60h returns the output byte and clears output full.
// - the input buffer holds the last byte stored by a port write or a memory write in bits 7:0, upper bits read zero.
// - status, input and output registers answer on the ports only while emulation is on.
// - the emulation-on bit enables port decoding and the keyboard and mouse interrupts.
// - the mouse line is high while emulation is on and aux flag, output full and irq gate are all set.
`timescale 1ns/100ps
module legacy_kbd_emulation (
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  // strap and configuration
  input  wire logic        LEGACY_STRAP,
  input  wire logic        LEGACY_DECODE_SEL,
  input  wire logic [15:0] FS_IO_BASE,
  // memory-space register access
  input  wire logic        MEM_REQ,
  input  wire logic        MEM_WE,
  input  wire logic [8:0]  MEM_ADDR,
  input  wire logic [31:0] MEM_WDATA,
  output logic      [31:0] MEM_RDATA,
  output logic             MEM_ACK,
  // legacy I/O port access
  input  wire logic        IO_REQ,
  input  wire logic        IO_WE,
  input  wire logic [15:0] IO_ADDR,
  input  wire logic [7:0]  IO_WDATA,
  output logic             IO_CLAIM,
  output logic      [7:0]  IO_RDATA,
  output logic             IO_ACK,
  // interrupt lines
  output logic             KEYBOARD_IRQ,
  output logic             MOUSE_IRQ,
  output logic             EMULATION_IRQ
);

  typedef struct packed {
    logic        strap_meta;
    logic        strap_sync;
    logic [3:0]  control;
    logic [7:0]  output_byte;
    logic [31:0] mem_rdata;
    logic        mem_ack;
    logic [7:0]  io_rdata;
    logic        io_ack;
    logic        kbd_irq;
    logic        mouse_irq;
    logic        emu_irq;
  } emu_state_t;

  emu_state_t state_ff;
  emu_state_t nxt_state;

  emu_evt_if evt ();

  emu_status_flags u_flags (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .evt   (evt)
  );

  logic       strap_on;
  logic       emu_on;
  logic       base_ok;
  logic       port_hit;
  logic       hit_data;
  logic       hit_cmd;
  logic       out_full;
  logic       aux_flag;
  logic       irq_gate;
  logic       emu_int;
  logic [3:0] ctl_view;

  assign strap_on = state_ff.strap_sync;
  assign emu_on   = strap_on & state_ff.control[legacy_emu_pkg::CTL_EMU_ON];
  assign base_ok  = !LEGACY_DECODE_SEL | (FS_IO_BASE == legacy_emu_pkg::LEGACY_IO_BASE);
  assign hit_data = (IO_ADDR == legacy_emu_pkg::PORT_DATA);
  assign hit_cmd  = (IO_ADDR == legacy_emu_pkg::PORT_CMD);
  assign port_hit = IO_REQ & emu_on & base_ok & (hit_data | hit_cmd);
  assign IO_CLAIM = port_hit;

  assign out_full = evt.status[legacy_emu_pkg::STS_OUT_FULL];
  assign aux_flag = evt.status[legacy_emu_pkg::STS_AUX];
  assign irq_gate = state_ff.control[legacy_emu_pkg::CTL_IRQ_GATE];
  assign emu_int  = emu_on & (evt.status[legacy_emu_pkg::STS_IN_FULL]
                    | (!out_full & state_ff.control[legacy_emu_pkg::CTL_CHAR_PEND]));

  always_comb begin
    ctl_view = state_ff.control;
    ctl_view[legacy_emu_pkg::CTL_EMU_INT] = emu_int;
  end

  // port events towards the flag unit
  always_comb begin
    evt.port_wr      = port_hit & IO_WE;
    evt.port_cmd     = hit_cmd;
    evt.port_data    = IO_WDATA;
    evt.port_rd_data = port_hit & !IO_WE & hit_data;
  end

  // memory-space stores into the flag unit
  always_comb begin
    evt.mem_data      = MEM_WDATA[7:0];
    evt.mem_wr_status = MEM_REQ & MEM_WE & strap_on
                        & legacy_emu_pkg::reg_hit(MEM_ADDR, legacy_emu_pkg::OFS_STATUS);
    evt.mem_wr_input  = MEM_REQ & MEM_WE & strap_on
                        & legacy_emu_pkg::reg_hit(MEM_ADDR, legacy_emu_pkg::OFS_INPUT);
  end

  always_comb begin
    nxt_state = state_ff;

    // two-stage strap synchroniser
    nxt_state.strap_meta = LEGACY_STRAP;
    nxt_state.strap_sync = state_ff.strap_meta;

    // memory window
    nxt_state.mem_ack   = MEM_REQ;
    nxt_state.mem_rdata = legacy_emu_pkg::WORD_ZERO;
    if (MEM_REQ && strap_on) begin
      if (MEM_WE) begin
        if (legacy_emu_pkg::reg_hit(MEM_ADDR, legacy_emu_pkg::OFS_CONTROL)) begin
          nxt_state.control = MEM_WDATA[3:0];
          nxt_state.control[legacy_emu_pkg::CTL_EMU_INT] = 1'b0;
        end
        if (legacy_emu_pkg::reg_hit(MEM_ADDR, legacy_emu_pkg::OFS_OUTPUT)) begin
          nxt_state.output_byte = MEM_WDATA[7:0];
        end
      end else begin
        if (legacy_emu_pkg::reg_hit(MEM_ADDR, legacy_emu_pkg::OFS_CONTROL)) begin
          nxt_state.mem_rdata = {28'h0000000, ctl_view};
        end
        if (legacy_emu_pkg::reg_hit(MEM_ADDR, legacy_emu_pkg::OFS_INPUT)) begin
          nxt_state.mem_rdata = {24'h000000, evt.input_byte};
        end
        if (legacy_emu_pkg::reg_hit(MEM_ADDR, legacy_emu_pkg::OFS_OUTPUT)) begin
          nxt_state.mem_rdata = {24'h000000, state_ff.output_byte};
        end
        if (legacy_emu_pkg::reg_hit(MEM_ADDR, legacy_emu_pkg::OFS_STATUS)) begin
          nxt_state.mem_rdata = {24'h000000, evt.status};
        end
      end
    end

    // legacy port answers
    nxt_state.io_ack   = port_hit;
    nxt_state.io_rdata = legacy_emu_pkg::BYTE_RESET;
    if (port_hit && !IO_WE) begin
      if (hit_data) begin
        nxt_state.io_rdata = state_ff.output_byte;
      end else begin
        nxt_state.io_rdata = evt.status;
      end
    end

    nxt_state.kbd_irq   = emu_on & irq_gate & out_full & !aux_flag;
    nxt_state.mouse_irq = emu_on & irq_gate & out_full & aux_flag;
    nxt_state.emu_irq   = emu_int;
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state_ff <= '{strap_meta:  1'b0,
                    strap_sync:  1'b0,
                    control:     legacy_emu_pkg::CONTROL_RESET,
                    output_byte: legacy_emu_pkg::BYTE_RESET,
                    mem_rdata:   legacy_emu_pkg::WORD_ZERO,
                    mem_ack:     1'b0,
                    io_rdata:    legacy_emu_pkg::BYTE_RESET,
                    io_ack:      1'b0,
                    kbd_irq:     1'b0,
                    mouse_irq:   1'b0,
                    emu_irq:     1'b0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign MEM_RDATA     = state_ff.mem_rdata;
  assign MEM_ACK       = state_ff.mem_ack;
  assign IO_RDATA      = state_ff.io_rdata;
  assign IO_ACK        = state_ff.io_ack;
  assign KEYBOARD_IRQ  = state_ff.kbd_irq;
  assign MOUSE_IRQ     = state_ff.mouse_irq;
  assign EMULATION_IRQ = state_ff.emu_irq;

endmodule // legacy_kbd_emulation

//--- verification/legacy_emu_chk.sv
// port assertions for the legacy keyboard/mouse emulation
`timescale 1ns/100ps
module legacy_emu_chk (
  // clock and reset
  input wire logic        CLOCK,
  input wire logic        RST_N,
  // configuration
  input wire logic        LEGACY_STRAP,
  input wire logic        LEGACY_DECODE_SEL,
  input wire logic [15:0] FS_IO_BASE,
  // memory and port cycles
  input wire logic        MEM_REQ,
  input wire logic        MEM_ACK,
  input wire logic        IO_REQ,
  input wire logic        IO_WE,
  input wire logic [15:0] IO_ADDR,
  input wire logic        IO_CLAIM,
  input wire logic [7:0]  IO_RDATA,
  input wire logic        IO_ACK,
  // interrupt lines
  input wire logic        KEYBOARD_IRQ,
  input wire logic        MOUSE_IRQ
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  wire io_go = IO_REQ && IO_CLAIM;
  sequence rd_s(a); io_go && !IO_WE && IO_ADDR == a; endsequence
  sequence wr_s(a); io_go && IO_WE && IO_ADDR == a; endsequence

  mem_ack_a: assert property (MEM_REQ |=> MEM_ACK)
    else $error("memory cycle not acked");
  io_ack_a: assert property (io_go |=> IO_ACK)
    else $error("claimed port cycle not acked");
  io_quiet_a: assert property (!io_go |=> !IO_ACK)
    else $error("port ack without claim");
  claim_port_a: assert property (IO_CLAIM |-> IO_REQ && IO_ADDR inside {16'h0060, 16'h0064})
    else $error("claim outside ports 60h and 64h");
  strap_off_a: assert property (!LEGACY_STRAP [*3] |-> !IO_CLAIM)
    else $error("port claimed with strap low");
  base_qual_a: assert property (LEGACY_DECODE_SEL && FS_IO_BASE != 16'h0060 |-> !IO_CLAIM)
    else $error("port claimed with base not 60h");
  status_still_a: assert property (rd_s(16'h0064) ##1 rd_s(16'h0064) |=> IO_RDATA == $past(IO_RDATA))
    else $error("status read changed status");
  out_clear_a: assert property (rd_s(16'h0060) ##1 rd_s(16'h0064) |=> !IO_RDATA[0])
    else $error("output full not cleared");
  data_flags_a: assert property (wr_s(16'h0060) ##1 rd_s(16'h0064) |=> IO_RDATA[1] && !IO_RDATA[3])
    else $error("data write flags wrong");
  cmd_flags_a: assert property (wr_s(16'h0064) ##1 rd_s(16'h0064) |=> IO_RDATA[1] && IO_RDATA[3])
    else $error("command write flags wrong");
  irq_excl_a: assert property (!(KEYBOARD_IRQ && MOUSE_IRQ))
    else $error("keyboard and mouse lines both high");

  cover property (wr_s(16'h0064));
  cover property (rd_s(16'h0060));
  cover property (MOUSE_IRQ);
  cover property (KEYBOARD_IRQ);
endmodule // legacy_emu_chk

//--- verification/legacy_host_model.sv
// host software model issuing memory and port cycles
`timescale 1ns/100ps
module legacy_host_model (
  // clock
  input wire logic         clk,
  // memory cycles
  output logic             mem_req,
  output logic             mem_we,
  output logic      [8:0]  mem_addr,
  output logic      [31:0] mem_wdata,
  // port cycles
  output logic             io_req,
  output logic             io_we,
  output logic      [15:0] io_addr,
  output logic      [7:0]  io_wdata,
  input  wire logic        io_claim,
  // firmware configuration
  output logic             decode_sel,
  output logic      [15:0] io_base
);
  logic [31:0] note_q[$];
  initial {mem_req, mem_we, mem_addr, mem_wdata, io_req, io_we, io_addr, io_wdata} = '0;
  initial {decode_sel, io_base} = {1'b0, 16'h0060};

  task automatic mem(input logic we, input logic [8:0] a, input logic [31:0] d, e);
    @(posedge clk);
    {mem_req, mem_we, mem_addr, mem_wdata, io_req} <= {1'b1, we, a, d, 1'b0};
    note_q.push_back(e);
  endtask

  task automatic io(input logic we, input logic [15:0] a, input logic [7:0] d, input logic ok,
                    input logic [31:0] e, output logic c);
    @(posedge clk);
    {io_req, io_we, io_addr, io_wdata, mem_req} <= {1'b1, we, a, d, 1'b0};
    if (ok) note_q.push_back(e);
    @(negedge clk);
    c = io_claim;
  endtask

  // released lines stop showing the last value
  task automatic idle();
    @(posedge clk);
    {mem_req, io_req} <= 2'h0;
    {mem_addr, mem_wdata, io_addr, io_wdata} <= ~{mem_addr, mem_wdata, io_addr, io_wdata};
  endtask

  task automatic fw(input logic s, input logic [15:0] b);
    {decode_sel, io_base} <= {s, b};
  endtask
endmodule // legacy_host_model

//--- verification/test_legacy_kbd_emulation.sv
// self-checking bench for the legacy keyboard/mouse emulation
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s: expected %h seen %h", n, e, g); end end
`define HM u_legacy_host_model
module test_legacy_kbd_emulation;
  logic        clock, rst_n, strap, decode_sel, mem_req, mem_we, mem_ack;
  logic        io_req, io_we, io_claim, io_ack, kbd_irq, mouse_irq, emu_irq;
  logic [8:0]  mem_addr;
  logic [31:0] mem_wdata, mem_rdata, exp_v, got_v;
  logic [15:0] io_base, io_addr;
  logic [7:0]  io_wdata, io_rdata, b, ob, b3;
  int          fail_count = 0, compares = 0;

  legacy_kbd_emulation u_legacy_kbd_emulation (.CLOCK(clock), .RST_N(rst_n),
    .LEGACY_STRAP(strap), .LEGACY_DECODE_SEL(decode_sel), .FS_IO_BASE(io_base),
    .MEM_REQ(mem_req), .MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
    .MEM_RDATA(mem_rdata), .MEM_ACK(mem_ack), .IO_REQ(io_req), .IO_WE(io_we),
    .IO_ADDR(io_addr), .IO_WDATA(io_wdata), .IO_CLAIM(io_claim), .IO_RDATA(io_rdata),
    .IO_ACK(io_ack), .KEYBOARD_IRQ(kbd_irq), .MOUSE_IRQ(mouse_irq), .EMULATION_IRQ(emu_irq));
  legacy_host_model u_legacy_host_model (.clk(clock), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .io_req(io_req), .io_we(io_we),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_claim(io_claim), .decode_sel(decode_sel),
    .io_base(io_base));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic io(input logic we, input logic [15:0] a, input logic [7:0] d, input logic ok,
                    input logic [7:0] e);
    logic c;
    `HM.io(we, a, d, ok, {24'h0, e}, c);
    `CHK("port claim", ok, c)
  endtask

  // every ack takes the oldest note
  always @(posedge clock) begin
    if (mem_ack === 1'b1 || io_ack === 1'b1) begin
      exp_v = `HM.note_q.pop_front();
      got_v = mem_ack ? mem_rdata : {24'h0, io_rdata};
      `CHK("read data", exp_v, got_v)
    end
  end

  initial begin
    repeat (2000) @(posedge clock);
    fail_count++;
    stop_test();
  end

  initial begin
    rst_n = 1'b0;
    strap = 1'b0;
    void'($urandom(32'h23B8EDE8));
    {b, ob, b3} = {8'($urandom), 8'($urandom), 8'($urandom)};
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    `HM.mem(1'b1, 9'h100, 32'h1, 32'h0);
    `HM.mem(1'b0, 9'h100, 32'h0, 32'h0);
    io(1'b0, 16'h0064, 8'h00, 1'b0, 8'h00);
    `HM.idle();
    strap <= 1'b1;
    repeat (3) @(posedge clock);
    `HM.mem(1'b1, 9'h104, {24'hFFFFFF, b}, 32'h0);
    `HM.mem(1'b1, 9'h108, {24'h0, ob}, 32'h0);
    `HM.mem(1'b1, 9'h10C, 32'h21, 32'h0);
    `HM.mem(1'b1, 9'h100, 32'h9, 32'h0);
    `HM.mem(1'b0, 9'h104, 32'h0, {24'h0, b});
    `HM.mem(1'b0, 9'h108, 32'h0, {24'h0, ob});
    `HM.mem(1'b0, 9'h10C, 32'h0, 32'h21);
    `HM.mem(1'b0, 9'h100, 32'h0, 32'h9);
    `HM.mem(1'b0, 9'h110, 32'h0, 32'h0);
    `HM.idle();
    repeat (2) @(posedge clock);
    `CHK("mouse line", 1'b1, mouse_irq)
    `CHK("keyboard line", 1'b0, kbd_irq)
    io(1'b0, 16'h0064, 8'h00, 1'b1, 8'h21);
    io(1'b0, 16'h0064, 8'h00, 1'b1, 8'h21);
    io(1'b0, 16'h0060, 8'h00, 1'b1, ob);
    io(1'b0, 16'h0064, 8'h00, 1'b1, 8'h20);
    io(1'b1, 16'h0060, b, 1'b1, 8'h00);
    io(1'b0, 16'h0064, 8'h00, 1'b1, 8'h22);
    io(1'b1, 16'h0064, b3, 1'b1, 8'h00);
    io(1'b0, 16'h0064, 8'h00, 1'b1, 8'h2A);
    `HM.idle();
    `HM.mem(1'b0, 9'h104, 32'h0, {24'h0, b3});
    `HM.mem(1'b0, 9'h10C, 32'h0, 32'h2A);
    `HM.mem(1'b0, 9'h100, 32'h0, 32'hB);
    `HM.idle();
    `CHK("emulation line", 1'b1, emu_irq)
    for (int i = 0; i < 3; i++) begin
      `HM.fw(i > 0, i == 0 ? 16'($urandom) : (i == 1 ? 16'h0000 : 16'h0060));
      io(1'b0, 16'h0064, 8'h00, i != 1, 8'h2A);
      `HM.idle();
    end
    `HM.mem(1'b1, 9'h10C, 32'h1, 32'h0);
    `HM.idle();
    repeat (2) @(posedge clock);
    `CHK("keyboard line", 1'b1, kbd_irq)
    `CHK("mouse line", 1'b0, mouse_irq)
    `HM.mem(1'b1, 9'h100, 32'h0, 32'h0);
    io(1'b1, 16'h0060, ~b3, 1'b0, 8'h00);
    `HM.mem(1'b0, 9'h104, 32'h0, {24'h0, b3});
    `HM.idle();
    repeat (3) @(posedge clock);
    `CHK("emulation line", 1'b0, emu_irq)
    `CHK("keyboard line", 1'b0, kbd_irq)
    `CHK("notes left", 0, `HM.note_q.size())
    stop_test();
  end
endmodule // test_legacy_kbd_emulation

bind legacy_kbd_emulation legacy_emu_chk u_legacy_emu_chk (.CLOCK(CLOCK), .RST_N(RST_N),
  .LEGACY_STRAP(LEGACY_STRAP), .LEGACY_DECODE_SEL(LEGACY_DECODE_SEL), .FS_IO_BASE(FS_IO_BASE),
  .MEM_REQ(MEM_REQ), .MEM_ACK(MEM_ACK), .IO_REQ(IO_REQ), .IO_WE(IO_WE), .IO_ADDR(IO_ADDR),
  .IO_CLAIM(IO_CLAIM), .IO_RDATA(IO_RDATA), .IO_ACK(IO_ACK), .KEYBOARD_IRQ(KEYBOARD_IRQ),
  .MOUSE_IRQ(MOUSE_IRQ));
